// ---- inc/pof_map.vh ----
// register map, field positions, reset values for the pwm output stage
`ifndef POF_MAP_VH
`define POF_MAP_VH
// =====================================================================
// register byte offsets
`define POF_FLT_CFG_ADDR 12'h000
`define POF_OVD_SEL_ADDR 12'h004
`define POF_OVD_LVL_ADDR 12'h008
`define POF_OUT_EN_ADDR 12'h00c
`define POF_GPIO_DAT_ADDR 12'h010
`define POF_GPIO_DIR_ADDR 12'h014
`define POF_PIN_STAT_ADDR 12'h018
// =====================================================================
// fault configuration fields
`define POF_FA_EN 0
`define POF_FA_MODE 1
`define POF_FA_STAT 2
`define POF_FLT_SCOPE 3
`define POF_FB_EN 4
`define POF_FB_MODE 5
`define POF_FB_STAT 6
`define POF_BRK_EN 7
// =====================================================================
// reset values
`define POF_FLT_CFG_RST 8'h00
`define POF_OVD_SEL_RST 8'hff
`define POF_OVD_LVL_RST 8'h00
`define POF_OUT_EN_OFF 3'h0
`define POF_OUT_EN_EIGHT 3'h5
`define POF_OUT_EN_SIX 3'h4
`define POF_GPIO_RST 8'h00
`endif

// ---- hdl/pof_fault_chan.v ----
// one fault input channel: status flag, latched or cycle-by-cycle hold
`timescale 1ns/1ps
`default_nettype none
module pof_fault_chan (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // fault pin and period event
  input wire faultIn_n,
  input wire periodStart,
  // configuration
  input wire enable,
  input wire cycleMode,
  // software clear of the status flag
  input wire swClear,
  // state
  output reg status,
  output wire blocking
);
  // =====================================================================
  // status and hold
  wire asserted;
  reg hold;
  assign asserted = enable & ~faultIn_n; // RULE8 RULE9
  assign blocking = asserted | hold; // RULE10
  // set wins over any clear; release waits for the next period start
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= 1'b0;
      hold <= 1'b0;
    end else if (asserted) begin
      status <= 1'b1; // RULE13
      hold <= 1'b1;
    end else if (cycleMode) begin
      if (periodStart) begin
        status <= 1'b0; // RULE12
        hold <= 1'b0;
      end
    end else begin
      if (swClear) begin
        status <= 1'b0; // RULE20
      end
      if (!status && periodStart) begin
        hold <= 1'b0; // RULE11
      end
    end
  end
endmodule // pof_fault_chan
`default_nettype wire

// ---- hdl/pof_pin_mux.v ----
// per-pin level selection: override, fault, polarity and pin ownership
`timescale 1ns/1ps
`default_nettype none
module pof_pin_mux #(
  parameter NPINS = 8
) (
  // waveform and override
  input wire [NPINS-1:0] dutyIn,
  input wire [NPINS-1:0] overrideSel,
  input wire [NPINS-1:0] manualLevel,
  input wire [NPINS-1:0] faultMask,
  // polarity
  input wire highSidePolarity,
  input wire lowSidePolarity,
  // ownership
  input wire [NPINS-1:0] pinOwned,
  input wire [NPINS-1:0] gpioData,
  input wire [NPINS-1:0] gpioDir,
  // pin drive
  output wire [NPINS-1:0] pinOut,
  output wire [NPINS-1:0] pinOe
);
  // =====================================================================
  // one generated slice per pin
  genvar i;
  generate
    for (i = 0; i < NPINS; i = i + 1) begin : g_pin
      wire act;
      wire pol;
      // set select follows the comparator, clear follows the manual level
      assign act = (overrideSel[i] ? dutyIn[i] : manualLevel[i])
        & ~faultMask[i]; // RULE19 RULE18 RULE14
      // odd pins are high side; polarity applies to every level of an owned pin, not to gpio data
      assign pol = (i % 2 == 1) ? highSidePolarity : lowSidePolarity;
      assign pinOut[i] = pinOwned[i] ? (act ^ pol)
        : gpioData[i]; // RULE1 RULE2 RULE3 RULE5
      assign pinOe[i] = pinOwned[i] | gpioDir[i]; // RULE5 RULE6
    end
  endgenerate
endmodule // pof_pin_mux
`default_nettype wire

// ---- hdl/pof_output_stage.v ----
// pwm output stage: faults, override, polarity, pin ownership, ahb regs
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pof_map.vh"
// Functional notes
// RULE1 - high-side polarity 0 gives active-high odd pins, 1 active-low
// RULE2 - low-side polarity clear gives active-high even pins, set active-low
// RULE3 - every level, fault and override included, passes polarity
// RULE4 - default polarity settings give active-high outputs
// RULE5 - enabled pin pairs ignore gpio data and direction
// RULE6 - unprogrammed pin-reset option clears output enable field at reset
// RULE7 - programmed pin-reset option loads 101 (eight pins) or 100 (six)
// RULE8 - both fault inputs are active low
// RULE9 - a fault acts only when its own enable is set
// RULE10 - fault response is pure hardware, no software needed
// RULE11 - latched mode holds until input high, flag cleared, period start
// RULE12 - cycle mode holds while low, resumes and self-clears at period
// RULE13 - status reads 1 while fault asserted or latched, else 0
// RULE14 - scope 1 kills all outputs, scope 0 only outputs 0 to 5
// RULE15 - breakpoint enable plus debug halt forces outputs inactive
// RULE16 - firmware should enable breakpoint fault when debugging power stages
// RULE17 - software may step manual levels for six-step commutation
// RULE18 - select 11000011 with zero levels runs pins 0,1,6,7 only
// RULE19 - clear select follows manual level, set select follows duty
// RULE20 - writing 0 to status clears it only once the fault is gone
module pof_output_stage #(
  parameter NPINS = 8,
  parameter EIGHT_PIN_VARIANT = 1
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // device configuration word bits
  input wire highSidePolarity,
  input wire lowSidePolarity,
  input wire pinResetOption_n,
  // from the waveform core
  input wire [NPINS-1:0] dutyIn,
  input wire periodStart,
  input wire debugHaltActive,
  // fault inputs, active low
  input wire faultInputA_n,
  input wire faultInputB_n,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // gate driver pins
  output reg [NPINS-1:0] pinOut,
  output reg [NPINS-1:0] pinOe
);
  // =====================================================================
  // registers
  reg [7:0] fltCfg;
  reg [7:0] overrideSel;
  reg [7:0] manualLevel;
  reg [2:0] outputEnableField;
  reg [7:0] gpioData;
  reg [7:0] gpioDir;
  reg initDone;
  reg wrPend;
  reg [11:0] wrAddr;
  wire statusA;
  wire statusB;
  wire blockA;
  wire blockB;
  wire clrA;
  wire clrB;
  wire cfgWrite;
  wire faultActive;
  wire [NPINS-1:0] faultMask;
  wire [NPINS-1:0] pinOwned;
  wire [NPINS-1:0] next_pinOut;
  wire [NPINS-1:0] next_pinOe;
  wire addrPhase;
  wire fwdHit;
  wire [7:0] fwdByte;
  wire [7:0] cfgView;
  reg [31:0] next_hrdata;

  // =====================================================================
  // ahb address phase capture; slave never inserts wait states
  assign addrPhase = hsel & hready & htrans[1];
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wrPend <= addrPhase & hwrite;
        wrAddr <= haddr;
      end
    end
  end

  // a write still in its data phase lands on the same edge that captures a
  // back-to-back read, so its byte is forwarded to avoid a stale answer
  assign fwdHit = wrPend && initDone && (wrAddr == haddr);
  assign fwdByte = hwdata[7:0];
  assign cfgView = fwdHit ? fwdByte : fltCfg;

  // read data is registered at the address phase so it stands in data phase
  always @* begin
    next_hrdata = 32'h0000_0000;
    case (haddr)
      `POF_FLT_CFG_ADDR: next_hrdata = {24'h000000, cfgView[7],
        statusB, cfgView[5:3], statusA, cfgView[1:0]}; // RULE13
      `POF_OVD_SEL_ADDR: next_hrdata = {24'h000000,
        fwdHit ? fwdByte : overrideSel};
      `POF_OVD_LVL_ADDR: next_hrdata = {24'h000000,
        fwdHit ? fwdByte : manualLevel};
      `POF_OUT_EN_ADDR: next_hrdata = {29'h00000000,
        fwdHit ? fwdByte[2:0] : outputEnableField};
      `POF_GPIO_DAT_ADDR: next_hrdata = {24'h000000,
        fwdHit ? fwdByte : gpioData};
      `POF_GPIO_DIR_ADDR: next_hrdata = {24'h000000,
        fwdHit ? fwdByte : gpioDir};
      `POF_PIN_STAT_ADDR: next_hrdata = {16'h0000, pinOe, pinOut};
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // =====================================================================
  // register writes; status bits are owned by the fault channels
  assign cfgWrite = wrPend && (wrAddr == `POF_FLT_CFG_ADDR);
  assign clrA = cfgWrite & ~hwdata[`POF_FA_STAT]; // RULE20
  assign clrB = cfgWrite & ~hwdata[`POF_FB_STAT]; // RULE20

  // the output enable field is loaded from the strap one edge after release,
  // since an async reset may only load constants
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fltCfg <= `POF_FLT_CFG_RST;
      overrideSel <= `POF_OVD_SEL_RST;
      manualLevel <= `POF_OVD_LVL_RST;
      outputEnableField <= `POF_OUT_EN_OFF; // RULE6
      gpioData <= `POF_GPIO_RST;
      gpioDir <= `POF_GPIO_RST;
      initDone <= 1'b0;
    end else if (!initDone) begin
      initDone <= 1'b1;
      if (!pinResetOption_n) begin
        outputEnableField <= (EIGHT_PIN_VARIANT != 0) ? `POF_OUT_EN_EIGHT
          : `POF_OUT_EN_SIX; // RULE7
      end
    end else if (wrPend) begin
      case (wrAddr)
        `POF_FLT_CFG_ADDR: fltCfg <= hwdata[7:0];
        `POF_OVD_SEL_ADDR: overrideSel <= hwdata[7:0];
        `POF_OVD_LVL_ADDR: manualLevel <= hwdata[7:0];
        `POF_OUT_EN_ADDR: outputEnableField <= hwdata[2:0];
        `POF_GPIO_DAT_ADDR: gpioData <= hwdata[7:0];
        `POF_GPIO_DIR_ADDR: gpioDir <= hwdata[7:0];
        default: fltCfg <= fltCfg;
      endcase
    end
  end

  // =====================================================================
  // fault channels
  pof_fault_chan u_faultA (
    .clock(clock),
    .rst_n(rst_n),
    .faultIn_n(faultInputA_n),
    .periodStart(periodStart),
    .enable(fltCfg[`POF_FA_EN]),
    .cycleMode(fltCfg[`POF_FA_MODE]),
    .swClear(clrA),
    .status(statusA),
    .blocking(blockA)
  );

  pof_fault_chan u_faultB (
    .clock(clock),
    .rst_n(rst_n),
    .faultIn_n(faultInputB_n),
    .periodStart(periodStart),
    .enable(fltCfg[`POF_FB_EN]),
    .cycleMode(fltCfg[`POF_FB_MODE]),
    .swClear(clrB),
    .status(statusB),
    .blocking(blockB)
  );

  // breakpoint fault is a plain level: it ends when the halt ends
  assign faultActive = blockA | blockB
    | (fltCfg[`POF_BRK_EN] & debugHaltActive); // RULE15 RULE10

  // =====================================================================
  // fault scope and pin ownership
  genvar p;
  generate
    for (p = 0; p < NPINS; p = p + 1) begin : g_own
      // pins 6 and 7 escape a fault when the scope bit is clear
      assign faultMask[p] = faultActive
        & ((p < 6) | fltCfg[`POF_FLT_SCOPE]); // RULE14
      // field value n enables pairs 0..n-1, so 101 owns all eight pins
      assign pinOwned[p] = ((p / 2) < outputEnableField); // RULE5
    end
  endgenerate

  pof_pin_mux #(
    .NPINS(NPINS)
  ) u_mux (
    .dutyIn(dutyIn),
    .overrideSel(overrideSel[NPINS-1:0]),
    .manualLevel(manualLevel[NPINS-1:0]),
    .faultMask(faultMask),
    .highSidePolarity(highSidePolarity), // RULE4
    .lowSidePolarity(lowSidePolarity),
    .pinOwned(pinOwned),
    .gpioData(gpioData[NPINS-1:0]),
    .gpioDir(gpioDir[NPINS-1:0]),
    .pinOut(next_pinOut),
    .pinOe(next_pinOe)
  );

  // =====================================================================
  // pin registers; reset leaves every pin released (tri-stated)
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= {NPINS{1'b0}};
      pinOe <= {NPINS{1'b0}}; // RULE6
    end else begin
      pinOut <= next_pinOut; // RULE3
      pinOe <= next_pinOe;
    end
  end
endmodule // pof_output_stage
`default_nettype wire

// ---- verif/pof_output_stage_asserts.sv ----
// checker for the pwm output stage: reset pins, faults, bus answer
`timescale 1ns/1ps
`default_nettype none
module pof_output_stage_asserts #(
  parameter NPINS = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // straps and core side
  input wire logic highSidePolarity,
  input wire logic lowSidePolarity,
  input wire logic pinResetOption_n,
  input wire logic periodStart,
  input wire logic debugHaltActive,
  input wire logic faultInputA_n,
  input wire logic faultInputB_n,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic [NPINS-1:0] pinOut,
  input wire logic [NPINS-1:0] pinOe
);
  logic cfgWr;
  logic [7:0] cfg;
  logic [7:0] idle;
  // ==========================================================
  // shadow of fault configuration writes, the enables live inside
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgWr <= 1'b0;
      cfg <= 8'h00;
    end else begin
      cfgWr <= hsel && htrans[1] && hwrite && haddr == 12'h000;
      if (cfgWr) cfg <= hwdata[7:0];
    end
  end
  // driven pins still at their active level after polarity
  assign idle = (pinOut ^ {4{highSidePolarity, lowSidePolarity}}) & pinOe;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  rst_pins_a: assert property (disable iff (1'b0)
    !rst_n |-> pinOut == 0 && pinOe == 0) else $error("pins live in reset");
  strap_oe_a: assert property ($rose(rst_n) |-> ##2
    pinOe == (pinResetOption_n ? 8'h00 : 8'hff)) else $error("strap oe");
  fault_a_a: assert property (cfg[0] && !faultInputA_n |=>
    (idle & (cfg[3] ? 8'hff : 8'h3f)) == 0) else $error("fault a pins");
  fault_b_a: assert property (cfg[4] && !faultInputB_n |=>
    (idle & (cfg[3] ? 8'hff : 8'h3f)) == 0) else $error("fault b pins");
  brk_fault_a: assert property (cfg[7] && debugHaltActive |=>
    (idle & 8'h3f) == 0) else $error("breakpoint pins");
  hold_a_a: assert property (cfg[0] && $rose(faultInputA_n) &&
    !periodStart |=> (idle & 8'h3f) == 0) else $error("early resume a");
  hold_b_a: assert property (cfg[4] && $rose(faultInputB_n) &&
    !periodStart |=> (idle & 8'h3f) == 0) else $error("early resume b");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer");
  // main scenarios reached
  cover property (cfg[0] && !faultInputA_n);
  cover property (cfg[4] && $rose(faultInputB_n));
  cover property (cfg[7] && debugHaltActive);
endmodule // pof_output_stage_asserts
bind pof_output_stage pof_output_stage_asserts #(.NPINS(NPINS)) i_chk (
  .clock, .rst_n, .highSidePolarity, .lowSidePolarity, .pinResetOption_n,
  .periodStart, .debugHaltActive, .faultInputA_n, .faultInputB_n, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hreadyout, .hresp, .pinOut, .pinOe);
`default_nettype wire

// ---- verif/pof_inverter_model.sv ----
// far side: open-drain fault sources and inverter gate driver inputs
`timescale 1ns/1ps
`default_nettype none
module pof_inverter_model (
  // pin drive from the stage
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  // fault sources, each bit pulls its line low
  input wire logic [3:0] pullA,
  input wire logic [3:0] pullB,
  // shared fault lines and gate levels
  output logic faultA_n,
  output logic faultB_n,
  output logic [7:0] gate
);
  // pulled-up shared lines: any source wins, so sources can be or-ed
  assign faultA_n = ~|pullA;
  assign faultB_n = ~|pullB;
  // a released pin falls to the gate driver pull-down
  assign gate = pinOe & pinOut;
endmodule // pof_inverter_model
`default_nettype wire

// ---- verif/pwm_output_fault_polarity_stage_bench.sv ----
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module pwm_output_fault_polarity_stage_bench;
  logic clock, rst_n, hp, lp, pinReset_n, per, halt, hsel, hwrite;
  logic hreadyout, hresp, fA, fB;
  logic [11:0] haddr;
  logic [1:0] htrans, obs;
  logic [31:0] hwdata, hrdata, ex, seen, r;
  logic [7:0] duty, pinOut, pinOe, gate, pol;
  logic [3:0] pullA, pullB;
  logic [31:0] expQ[$];
  logic [11:0] regA[6] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014,
    12'h020};
  logic [7:0] regR[6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] six[6] = '{8'h24, 8'h21, 8'h09, 8'h18, 8'h12, 8'h06};
  int failures, checked, cyc;
  assign pol = {4{hp, lp}};
  pof_output_stage i_pof_output_stage (
    .clock, .rst_n, .highSidePolarity(hp), .lowSidePolarity(lp),
    .pinResetOption_n(pinReset_n), .dutyIn(duty), .periodStart(per),
    .debugHaltActive(halt), .faultInputA_n(fA), .faultInputB_n(fB),
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pinOut, .pinOe);
  pof_inverter_model i_pof_inverter_model (
    .pinOut, .pinOe, .pullA, .pullB, .faultA_n(fA), .faultB_n(fB), .gate);
  // ==========================================================
  // clock, hang guard and result watcher
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  // negedge keeps the compare away from the launching edge
  always @(negedge clock) begin
    if (obs != 2'h0) begin
      ex = expQ.pop_front();
      seen = (obs == 2'h1) ? hrdata : {24'h0, gate};
      `CMP(obs == 2'h1 ? "hrdata" : "gate", ex, seen)
      obs = 2'h0;
    end
  end
  // ==========================================================
  // drivers
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    expQ.push_back(e);
    obs <= 2'h1;
  endtask
  task automatic pins(input logic [7:0] e);
    @(posedge clock);
    expQ.push_back({24'h0, e});
    obs <= 2'h2;
  endtask
  task automatic pulse();
    @(posedge clock) per <= 1'b1;
    @(posedge clock) per <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // three strap and polarity settings, each after a fresh reset
  initial begin
    {rst_n, hp, lp, pinReset_n, per, halt, hsel, hwrite} = 8'h00;
    {haddr, htrans, hwdata, obs, pullA, pullB} = 0;
    {failures, checked, cyc} = 0;
    duty = $urandom(93);
    for (int ph = 0; ph < 3; ph++) begin
      @(posedge clock);
      {hp, lp, pinReset_n} <= ph == 0 ? 3'h0 : ph == 1 ? 3'h5 : 3'h2;
      rst_n <= 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rd(12'h00c, pinReset_n ? 0 : 5);
      pins(pinReset_n ? 8'h00 : duty ^ pol);
      rd(12'h018, pinReset_n ? 0 : {16'h0, 8'hff, duty ^ pol});
      foreach (regA[i]) rd(regA[i], regR[i]);
      bus(1'b1, 12'h00c, 4);
      r = $urandom;
      @(posedge clock) duty <= r[7:0];
      pins(r[7:0] ^ pol);
      bus(1'b1, 12'h004, 0);
      foreach (six[i]) begin
        bus(1'b1, 12'h008, six[i]);
        pins(six[i] ^ pol);
      end
      bus(1'b1, 12'h008, 0);
      bus(1'b1, 12'h004, 8'hc3);
      pins((r[7:0] & 8'hc3) ^ pol);
      bus(1'b1, 12'h004, 8'hff);
      @(posedge clock) duty <= 8'hff;
      // latched fault a, two sources sharing the line, all pins
      bus(1'b1, 12'h000, 8'h09);
      @(posedge clock) pullA <= 4'h3;
      pins(pol);
      bus(1'b1, 12'h000, 8'h09);
      rd(12'h000, 8'h0d);
      @(posedge clock) pullA <= 4'h0;
      pins(pol);
      bus(1'b1, 12'h000, 8'h09);
      rd(12'h000, 8'h09);
      pins(pol);
      pulse();
      pins(8'hff ^ pol);
      // cycle-by-cycle fault b, outputs 6 and 7 keep running
      bus(1'b1, 12'h000, 8'h30);
      @(posedge clock) pullB <= 4'h8;
      pins(8'hc0 ^ pol);
      rd(12'h000, 8'h70);
      @(posedge clock) pullB <= 4'h0;
      pins(8'hc0 ^ pol);
      pulse();
      pins(8'hff ^ pol);
      rd(12'h000, 8'h30);
      // both enables clear: faults are ignored
      bus(1'b1, 12'h000, 8'h00);
      @(posedge clock) {pullA, pullB} <= 8'h11;
      pins(8'hff ^ pol);
      rd(12'h000, 8'h00);
      @(posedge clock) {pullA, pullB} <= 8'h00;
      // debugger attached to the power stage: breakpoint fault on
      bus(1'b1, 12'h000, 8'h88);
      @(posedge clock) halt <= 1'b1;
      pins(pol);
      @(posedge clock) halt <= 1'b0;
      pins(8'hff ^ pol);
      // general-purpose control, then pair 0 taken back
      bus(1'b1, 12'h00c, 0);
      bus(1'b1, 12'h014, 8'hff);
      bus(1'b1, 12'h010, 8'ha5);
      pins(8'ha5);
      bus(1'b1, 12'h00c, 1);
      pins({6'h29, ~pol[1:0]});
      rd(12'h018, {16'h0, 8'hff, 6'h29, ~pol[1:0]});
    end
    repeat (2) @(posedge clock);
    tally_and_finish();
  end
endmodule // pwm_output_fault_polarity_stage_bench
`default_nettype wire
